// >>> bench/msrg_gate_bench.sv
// Self-checking bench for the select gate and filtered reset
`timescale 1ns/1ps
module msrg_gate_bench;
    import msrg_pkg::*;
    localparam int unsigned MIN = 4; // Short filter keeps the run brief
    logic                 clk           = 1'b0;
    logic                 reset         = 1'b1;
    logic                 tgt_sda_oe    = 1'b0;
    logic                 setting_we    = 1'b0;
    logic [SETTING_W-1:0] setting_wdata = 8'h00;
    logic                 sel_in, sel_oe, rst_in, rst_oe, sda_oe, sda_out, tgt_enable;
    logic                 pulse, in_reset, en_prev;
    logic [SETTING_W-1:0] setting_q, v;
    logic [1:0]           notes[$]; // Bit 1 marks a pulse, bit 0 the enable level
    logic [1:0]           n;
    int                   fails = 0, checks_done = 0, cycles = 0, seed = 32'h4ef17199;
    always #5 clk = ~clk;
    msrg_host msrg_host_i (.clk(clk), .sel_in(sel_in), .sel_oe(sel_oe), .rst_in(rst_in),
        .rst_oe(rst_oe));
    msrg_gate #(.MIN_RESET_CYCLES(MIN)) msrg_gate_i (.clk(clk), .reset(reset),
        .module_select_n_in(sel_in), .module_select_n_oe(sel_oe), .module_reset_n_in(rst_in),
        .module_reset_n_oe(rst_oe), .tgt_sda_oe(tgt_sda_oe), .sda_oe(sda_oe),
        .sda_out(sda_out), .tgt_enable(tgt_enable), .module_reset_pulse(pulse),
        .module_in_reset(in_reset), .setting_we(setting_we), .setting_wdata(setting_wdata),
        .setting_q(setting_q));
    //////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watcher: every enable change or pulse consumes the oldest note
    always @(posedge clk) begin
        #1;
        cycles++;
        if (cycles > 3000) begin
            fails++;
            results();
        end else begin
            if (!reset && (tgt_enable !== en_prev || pulse === 1'b1)) begin
                if (notes.size() == 0) chk("unexpected event", 8'h00, 8'h01);
                else begin
                    n = notes.pop_front();
                    chk("event kind", {7'h0, n[1]}, {7'h0, pulse});
                    if (!n[1]) chk("tgt_enable", {7'h0, n[0]}, {7'h0, tgt_enable});
                end
            end
            en_prev = tgt_enable;
        end
    end
    //////////////////////////////////////////////////////////////////
    // Main sequence: select, deselect, release, then reset filtering
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        notes.push_back(2'b01);
        msrg_host_i.drive_sel(1'b1, 1'b0, 6);
        v = 8'($random(seed));
        @(posedge clk);
        tgt_sda_oe <= v[0];
        @(posedge clk);
        #1 chk("sda_oe selected", {7'h0, v[0]}, {7'h0, sda_oe});
        @(posedge clk);
        tgt_sda_oe <= ~v[0];
        @(posedge clk);
        #1 chk("sda_oe selected", {7'h0, ~v[0]}, {7'h0, sda_oe});
        @(posedge clk);
        tgt_sda_oe <= 1'b1;
        notes.push_back(2'b00);
        msrg_host_i.drive_sel(1'b1, 1'b1, 6);
        chk("sda_oe deselected", 8'h00, {7'h0, sda_oe});
        chk("sda_out", 8'h00, {7'h0, sda_out});
        msrg_host_i.drive_sel(1'b0, 1'b0, 8);
        chk("enable released", 8'h00, {7'h0, tgt_enable});
        $display("select tests done");
        @(posedge clk);
        setting_we <= 1'b1;
        setting_wdata <= v;
        @(posedge clk);
        setting_we <= 1'b0;
        #1 chk("setting written", v, setting_q);
        msrg_host_i.drive_rst(1'b1, 1'b0, MIN - 2);
        msrg_host_i.drive_rst(1'b1, 1'b1, 8);
        chk("setting after glitch", v, setting_q);
        notes.push_back(2'b10);
        msrg_host_i.drive_rst(1'b1, 1'b0, MIN + 8);
        chk("setting after reset", SETTING_DEFAULT, setting_q);
        chk("in reset", 8'h01, {7'h0, in_reset});
        msrg_host_i.drive_rst(1'b1, 1'b1, 6);
        msrg_host_i.drive_rst(1'b0, 1'b0, MIN + 10);
        chk("reset released", 8'h00, {7'h0, in_reset});
        chk("pending notes", 8'h00, 8'(notes.size()));
        $display("reset tests done");
        results();
    end
endmodule // msrg_gate_bench

// >>> bench/msrg_host.sv
// Host model driving the select and reset pins
`timescale 1ns/1ps
module msrg_host (
    input  wire logic clk,
    output logic      sel_in,
    output logic      sel_oe,
    output logic      rst_in,
    output logic      rst_oe
);
    // Pins start driven high: deselected, out of reset
    initial begin
        sel_in = 1'b1;
        sel_oe = 1'b1;
        rst_in = 1'b1;
        rst_oe = 1'b1;
    end
    //////////////////////////////////////////////////////////////////
    // Released pins show the inverse level, so only the pull-up helps
    task automatic drive_sel(input logic oe, input logic v, input int n);
        @(posedge clk);
        sel_oe <= oe;
        sel_in <= oe ? v : ~sel_in;
        repeat (n) @(posedge clk); // Assert or deassert wait
        #1;
    endtask
    task automatic drive_rst(input logic oe, input logic v, input int n);
        @(posedge clk);
        rst_oe <= oe;
        rst_in <= oe ? v : ~rst_in;
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule // msrg_host

// >>> verilog/msrg_gate.sv
// Select gate and filtered module reset for the 2-wire management target
`timescale 1ns/1ps
module msrg_gate
    import msrg_pkg::*;
#(
    parameter int unsigned MIN_RESET_CYCLES = RESET_MIN_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Select pin, two signals; oe high means driven
    input  wire logic                 module_select_n_in,
    input  wire logic                 module_select_n_oe,
    // Reset pin, two signals
    input  wire logic                 module_reset_n_in,
    input  wire logic                 module_reset_n_oe,
    // Data line from the inner target, and to the pad
    input  wire logic                 tgt_sda_oe,
    output logic                      sda_oe,
    output logic                      sda_out,
    // Gate towards the inner target
    output logic                      tgt_enable,
    // Module reset pulse and settings default
    output logic                      module_reset_pulse,
    output logic                      module_in_reset,
    input  wire logic                 setting_we,
    input  wire logic [SETTING_W-1:0] setting_wdata,
    output logic [SETTING_W-1:0]      setting_q
);
    //////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Level and drive enable of each pin pass two flops
    // before any logic sees them, so the pull-up mux reads only synchronised
    // values. The two paths of one pin may resolve a cycle apart on a change;
    // the select then glitches for one cycle at most, and the reset filter
    // swallows such a glitch anyway.
    localparam int unsigned PIN_N = 4;
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s;
    logic             sel_n_s;
    logic             rst_n_s;

    // Bit order: select level, select enable, reset level, reset enable
    assign pin_raw = {module_reset_n_oe, module_reset_n_in,
                      module_select_n_oe, module_select_n_in};

    // Flops start high, reading as deselected and out of reset
    for (genvar gi = 0; gi < PIN_N; gi++) begin : g_pin_sync
        msrg_sync #(.RESET_VAL(1'b1)) u_sync (
            .clk   (clk),
            .reset (reset),
            .din   (pin_raw[gi]),
            .dout  (pin_s[gi])
        );
    end

    // Pull-ups: an undriven pin reads high
    assign sel_n_s = pin_s[1] ? pin_s[0] : 1'b1;
    assign rst_n_s = pin_s[3] ? pin_s[2] : 1'b1;

    //////////////////////////////////////////////////////////////////////
    // Select gate. The assert and deassert waits are the host's duty; the
    // gate only adds three cycles of latency, which those waits cover.
    // Registering the gate delays a select glitch but still passes it to the data enable.
    logic sel_q;
    logic sel_d;

    always_comb begin
        sel_d = ~sel_n_s;
    end

    // Gate register
    always_ff @(posedge clk) begin
        if (reset) sel_q <= 1'b0;
        else       sel_q <= sel_d;
    end

    assign tgt_enable = sel_q;
    assign sda_oe     = sel_q & tgt_sda_oe;
    assign sda_out    = 1'b0;                 // Open drain pulls low only

    //////////////////////////////////////////////////////////////////////
    // Reset filter. A synchronised low in IDLE starts the count at zero;
    // the pulse fires once the count has reached MIN_RESET_CYCLES with the
    // pin still low. Any high sample during the count drops back to IDLE,
    // so short lows never touch the settings. HELD waits for the pin to
    // return high, which keeps one long low from firing twice.
    typedef enum logic [1:0] {MSRG_IDLE, MSRG_COUNT, MSRG_HELD} msrg_state_t;
    msrg_state_t     st_q;
    msrg_state_t     st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             pulse_q;
    logic             pulse_d;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        unique case (st_q)
            MSRG_IDLE: begin
                cnt_d = '0;
                if (!rst_n_s) st_d = MSRG_COUNT;
            end
            MSRG_COUNT: begin
                if (rst_n_s) begin
                    st_d = MSRG_IDLE;
                end else if (cnt_q >= CNT_W'(MIN_RESET_CYCLES)) begin
                    st_d    = MSRG_HELD;
                    pulse_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            MSRG_HELD: begin
                if (rst_n_s) st_d = MSRG_IDLE;
            end
            default: st_d = MSRG_IDLE; // Unused code falls back to IDLE
        endcase
    end

    // State, count and pulse registers
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q    <= MSRG_IDLE;
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    // Pulse comes straight from its flop; held level is decoded from the state flops
    assign module_reset_pulse = pulse_q;
    assign module_in_reset    = (st_q == MSRG_HELD);

    //////////////////////////////////////////////////////////////////////
    // User setting, restored to default by module reset. The reset wins
    // over a write in the same cycle, and writes stay blocked while HELD,
    // so software cannot change a setting before the module is released.
    logic [SETTING_W-1:0] set_q;
    logic [SETTING_W-1:0] set_d;

    always_comb begin
        set_d = set_q;
        if (pulse_d || module_in_reset) set_d = SETTING_DEFAULT;
        else if (setting_we)            set_d = setting_wdata;
    end

    // Setting register
    always_ff @(posedge clk) begin
        if (reset) set_q <= SETTING_DEFAULT;
        else       set_q <= set_d;
    end

    // Data output straight from the register
    assign setting_q = set_q;

    //////////////////////////////////////////////////////////////////////
    // Checks. Every property runs on the one clock and is off during the
    // block reset; pin checks look at synchronised values where they can.
    // Second-to-last count step of a low that is long enough
    sequence s_count_last;
        st_q == MSRG_COUNT && cnt_q == CNT_W'(MIN_RESET_CYCLES - 1);
    endsequence

    // Two low samples of the synchronised reset in a row
    sequence s_low_long;
        !rst_n_s [*2];
    endsequence

    // Select synchronised low for two samples in a row
    sequence s_sel_held;
        !sel_n_s [*2];
    endsequence

    a_desel_no_drive: assert property (@(posedge clk) disable iff (reset)
        !sel_q |-> !sda_oe) else $error("data driven while deselected");
    a_sel_follows: assert property (@(posedge clk) disable iff (reset)
        ##1 (sel_q == !$past(sel_n_s))) else $error("select gate lag wrong");
    a_sel_pullup: assert property (@(posedge clk) disable iff (reset)
        !module_select_n_oe [*3] |-> ##1 !sel_q) else $error("undriven select active");
    a_rst_pullup: assert property (@(posedge clk) disable iff (reset)
        !module_reset_n_oe [*3] |-> rst_n_s ##1 !pulse_q)
        else $error("undriven reset fired");
    a_short_ignored: assert property (@(posedge clk) disable iff (reset)
        (st_q == MSRG_COUNT && rst_n_s) |=> (st_q == MSRG_IDLE && !pulse_q))
        else $error("short reset not ignored");
    a_pulse_cause: assert property (@(posedge clk) disable iff (reset)
        pulse_q |-> $past(cnt_q) >= CNT_W'(MIN_RESET_CYCLES)) else $error("early reset");
    a_reset_restores: assert property (@(posedge clk) disable iff (reset)
        pulse_q |-> setting_q == SETTING_DEFAULT) else $error("setting not restored");
    a_long_low_fires: assert property (@(posedge clk) disable iff (reset)
        s_count_last ##0 s_low_long |=> pulse_q)
        else $error("long reset missed");
    a_held_single: assert property (@(posedge clk) disable iff (reset)
        pulse_q |=> !pulse_q) else $error("reset pulse repeated");
    a_sel_answers: assert property (@(posedge clk) disable iff (reset)
        s_sel_held |-> tgt_enable) else $error("selected target gated off");
    a_sda_passes: assert property (@(posedge clk) disable iff (reset)
        (tgt_enable && tgt_sda_oe) |-> sda_oe) else $error("data pull blocked");
    a_desel_gate: assert property (@(posedge clk) disable iff (reset)
        sel_n_s |=> !tgt_enable) else $error("deselected target enabled");
    a_count_steps: assert property (@(posedge clk) disable iff (reset)
        (st_q == MSRG_COUNT && !rst_n_s && cnt_q < CNT_W'(MIN_RESET_CYCLES))
        |=> (cnt_q == $past(cnt_q) + CNT_W'(1))) else $error("reset count skipped");
    a_held_level: assert property (@(posedge clk) disable iff (reset)
        (st_q == MSRG_HELD && !rst_n_s) |=> module_in_reset)
        else $error("module reset released early");
    a_hold_default: assert property (@(posedge clk) disable iff (reset)
        module_in_reset |=> (setting_q == SETTING_DEFAULT))
        else $error("setting written in reset");
endmodule // msrg_gate

// >>> verilog/msrg_pkg.sv
// Package of constants for the module select and reset gate
package msrg_pkg;
    // Default minimum reset pulse, in ns; the real figure is set elsewhere
    localparam int unsigned RESET_MIN_NS     = 1000;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    // Least time rounds up to whole cycles
    localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W            = 16;
    localparam logic [7:0]  SETTING_DEFAULT  = 8'h00;
    localparam int unsigned SETTING_W        = 8;
    localparam int unsigned TGT_ADDR_W       = 7;
    localparam logic [6:0]  TGT_ADDR_DEFAULT = 7'h50;
endpackage

// >>> verilog/msrg_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module msrg_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic dout_q;
    logic dout_d;

    // First stage feeds only the second stage
    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RESET_VAL;
            dout_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;
endmodule // msrg_sync
